// ==== rtl/csdr_host.sv ====
// host end: Avalon-MM register front end driving register commands
`timescale 1ns/1ns
module csdr_host #(
    parameter int unsigned READ_TIMEOUT_CYCLES = csdr_pkg::CSDR_READ_TIMEOUT_CYC,   // read wait
    parameter int unsigned WRITE_TIMEOUT_CYCLES = csdr_pkg::CSDR_WRITE_TIMEOUT_CYC  // write wait
) (
    input wire logic i_core_clk,              // core clock
    input wire logic i_rst,                   // synchronous reset, high
    input wire logic [5:0] i_avs_address,     // byte address
    input wire logic i_avs_read,              // read request
    input wire logic i_avs_write,             // write request
    input wire logic [31:0] i_avs_writedata,  // write data
    output logic [31:0] o_avs_readdata,       // read data
    output logic o_avs_waitrequest,           // stall
    csdr_if.host bus                          // link to card
);
    import csdr_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum {CSDR_H_IDLE, CSDR_H_WAIT} csdr_host_fsm_t;

    typedef struct packed {
        csdr_host_fsm_t fsm;
        logic ack;
        logic [31:0] readdata;
        logic req_valid;
        csdr_cmd_t cmd;
        logic [15:0] arg;
        logic [CSDR_TIMER_W-1:0] timer;
        logic done;
        logic timed_out;
        logic [127:0] data;
    } csdr_host_state_t;

    csdr_host_state_t s_q;
    csdr_host_state_t s_d;

    logic access;
    logic [CSDR_TIMER_W-1:0] limit;
    logic crc_ok;
    logic [31:0] status;
    logic [31:0] timing;
    logic [7:0] rate;
    logic [7:0] acc;
    logic [1:0] word_sel;

    assign access = (i_avs_read || i_avs_write) && !s_q.ack;
    // fixed limits, never derived from the card's timing codes
    assign limit = (s_q.cmd == CSDR_CMD_PROGRAM) ?
                   CSDR_TIMER_W'(WRITE_TIMEOUT_CYCLES - 1) :
                   CSDR_TIMER_W'(READ_TIMEOUT_CYCLES - 1);               // RULE_04
    assign crc_ok = (csdr_crc7(s_q.data[127:8]) == s_q.data[7:1]) && s_q.data[0]; // RULE_23
    assign rate = s_q.data[103:96];
    assign acc = s_q.data[119:112];
    assign word_sel = i_avs_address[3:2];

    // ------------------------------------------------------------
    // decoded views
    // ------------------------------------------------------------
    always_comb begin
        status = 32'h0;
        status[CSDR_ST_BUSY] = (s_q.fsm == CSDR_H_WAIT);
        status[CSDR_ST_DONE] = s_q.done;
        status[CSDR_ST_TIMEOUT] = s_q.timed_out;
        status[CSDR_ST_CRC_OK] = crc_ok;
        timing = 32'h0;
        // unit and multiplier split out, unsigned, msb first
        timing[CSDR_TM_RATE_LSB +: CSDR_UNIT_W] = rate[CSDR_UNIT_LSB +: CSDR_UNIT_W];    // RULE_06
        timing[CSDR_TM_RATE_LSB+4 +: CSDR_MULT_W] = rate[CSDR_MULT_LSB +: CSDR_MULT_W];  // RULE_06
        timing[CSDR_TM_ACC_LSB +: CSDR_UNIT_W] = acc[CSDR_UNIT_LSB +: CSDR_UNIT_W];      // RULE_03
        timing[CSDR_TM_ACC_LSB+4 +: CSDR_MULT_W] = acc[CSDR_MULT_LSB +: CSDR_MULT_W];    // RULE_19
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ack = access;
        if (access && i_avs_read) begin
            if (i_avs_address == CSDR_REG_ARG) begin
                s_d.readdata = {16'h0000, s_q.arg};
            end else if (i_avs_address == CSDR_REG_STATUS) begin
                s_d.readdata = status;
            end else if (i_avs_address == CSDR_REG_TIMING) begin
                s_d.readdata = timing;
            end else if (i_avs_address >= CSDR_REG_DATA0 && i_avs_address <= CSDR_REG_DATA3
                         && i_avs_address[1:0] == 2'h0) begin
                s_d.readdata = s_q.data[32*word_sel +: 32];
            end else begin
                s_d.readdata = 32'h0;
            end
        end
        // write lands on the edge where waitrequest is low
        if (s_q.ack && i_avs_write) begin
            if (i_avs_address == CSDR_REG_ARG) begin
                s_d.arg = i_avs_writedata[15:0];
            end else if (i_avs_address == CSDR_REG_CMD && s_q.fsm == CSDR_H_IDLE) begin
                s_d.cmd = csdr_cmd_t'(i_avs_writedata[2:0]);
                s_d.req_valid = 1'b1;
                s_d.timer = '0;
                s_d.done = 1'b0;
                s_d.timed_out = 1'b0;
                s_d.fsm = CSDR_H_WAIT;
            end
        end
        case (s_q.fsm)
            CSDR_H_IDLE: begin
            end
            CSDR_H_WAIT: begin
                if (bus.resp_valid) begin
                    s_d.data = bus.resp_data;
                    s_d.done = 1'b1;
                    s_d.req_valid = 1'b0;
                    s_d.fsm = CSDR_H_IDLE;
                end else if (s_q.timer == limit) begin
                    s_d.timed_out = 1'b1;                                 // RULE_04
                    s_d.req_valid = 1'b0;
                    s_d.fsm = CSDR_H_IDLE;
                end else begin
                    s_d.timer = s_q.timer + 1'b1;
                end
            end
            default: begin
                s_d.fsm = CSDR_H_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s_q.fsm <= CSDR_H_IDLE;
            s_q.ack <= 1'b0;
            s_q.readdata <= 32'h0;
            s_q.req_valid <= 1'b0;
            s_q.cmd <= CSDR_CMD_READ;
            s_q.arg <= 16'h0000;
            s_q.timer <= '0;
            s_q.done <= 1'b0;
            s_q.timed_out <= 1'b0;
            s_q.data <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_avs_readdata = s_q.readdata;
    assign o_avs_waitrequest = access;
    assign bus.req_valid = s_q.req_valid;
    assign bus.req_cmd = s_q.cmd;
    assign bus.req_arg = s_q.arg;

endmodule

// ==== rtl/csdr_pkg.sv ====
// shared constants, types and checksum for the card specific data register
package csdr_pkg;

    // ------------------------------------------------------------
    // clock and timeouts
    // ------------------------------------------------------------
    localparam int unsigned CSDR_CLK_HZ = 100_000_000;
    localparam int unsigned CSDR_READ_TIMEOUT_MS = 100;
    localparam int unsigned CSDR_WRITE_TIMEOUT_MS = 250;
    localparam int unsigned CSDR_READ_TIMEOUT_CYC = CSDR_READ_TIMEOUT_MS * (CSDR_CLK_HZ / 1000);
    localparam int unsigned CSDR_WRITE_TIMEOUT_CYC = CSDR_WRITE_TIMEOUT_MS * (CSDR_CLK_HZ / 1000);
    localparam int CSDR_TIMER_W = 25;

    // ------------------------------------------------------------
    // fixed field values
    // ------------------------------------------------------------
    localparam logic [1:0] CSDR_LAYOUT_V2 = 2'h1;
    localparam logic [7:0] CSDR_ACCESS_TIME = 8'h0E;
    localparam logic [7:0] CSDR_CLK_ACCESS = 8'h00;
    localparam logic [7:0] CSDR_RATE_DEFAULT = 8'h32;
    localparam logic [7:0] CSDR_RATE_HIGH = 8'h5A;
    localparam logic [11:0] CSDR_CMD_CLASSES = 12'h5B5;
    localparam logic [3:0] CSDR_BLOCK_LEN_512 = 4'h9;
    localparam logic [6:0] CSDR_SECTOR_SIZE = 7'h7F;
    localparam logic [2:0] CSDR_WRITE_SPEED = 3'h2;
    localparam logic [15:0] CSDR_DSR_RESET = 16'h0404;
    localparam int CSDR_SIZE_LIVE_W = 16;

    // ------------------------------------------------------------
    // code field layout, unit in 2:0, multiplier in 6:3
    // ------------------------------------------------------------
    localparam int CSDR_UNIT_LSB = 0;
    localparam int CSDR_UNIT_W = 3;
    localparam int CSDR_MULT_LSB = 3;
    localparam int CSDR_MULT_W = 4;

    // ------------------------------------------------------------
    // program and switch argument bits
    // ------------------------------------------------------------
    localparam int CSDR_ARG_TMP = 0;
    localparam int CSDR_ARG_PERM = 1;
    localparam int CSDR_ARG_COPY = 2;
    localparam int CSDR_ARG_HS = 0;

    // ------------------------------------------------------------
    // host register map (byte offsets) and status bits
    // ------------------------------------------------------------
    localparam logic [5:0] CSDR_REG_CMD = 6'h00;
    localparam logic [5:0] CSDR_REG_ARG = 6'h04;
    localparam logic [5:0] CSDR_REG_STATUS = 6'h08;
    localparam logic [5:0] CSDR_REG_TIMING = 6'h0C;
    localparam logic [5:0] CSDR_REG_DATA0 = 6'h10;
    localparam logic [5:0] CSDR_REG_DATA3 = 6'h1C;
    localparam int CSDR_ST_BUSY = 0;
    localparam int CSDR_ST_DONE = 1;
    localparam int CSDR_ST_TIMEOUT = 2;
    localparam int CSDR_ST_CRC_OK = 3;
    localparam int CSDR_TM_RATE_LSB = 0;
    localparam int CSDR_TM_ACC_LSB = 8;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CSDR_CMD_READ,
        CSDR_CMD_PROGRAM,
        CSDR_CMD_SWITCH,
        CSDR_CMD_IDLE,
        CSDR_CMD_SET_DSR
    } csdr_cmd_t;

    // field order from bit 127 down to bit 0
    typedef struct packed {
        logic [1:0] layout_version_code;
        logic [5:0] rsvd_125;
        logic [7:0] read_access_time_code;
        logic [7:0] clock_cycle_access_time;
        logic [7:0] transfer_rate_code;
        logic [11:0] command_classes;
        logic [3:0] max_read_block_length;
        logic partial_read_block_flag;
        logic write_misalignment_flag;
        logic read_misalignment_flag;
        logic driver_stage_present;
        logic [5:0] rsvd_75;
        logic [21:0] device_size;
        logic rsvd_47;
        logic single_block_erase_enable;
        logic [6:0] erase_sector_size;
        logic [6:0] protect_group_size;
        logic protect_group_enable;
        logic [1:0] rsvd_30;
        logic [2:0] write_speed_factor;
        logic [3:0] max_write_block_length;
        logic partial_write_block_flag;
        logic [4:0] rsvd_20;
        logic file_format_group_bit;
        logic copy_flag;
        logic permanent_protection_bit;
        logic temporary_protection_bit;
        logic [1:0] file_format;
        logic [1:0] rsvd_9;
        logic [6:0] checksum;
        logic stop_bit;
    } csdr_image_t;

    // seven-bit checksum, generator x^7 + x^3 + 1, msb first
    function automatic logic [6:0] csdr_crc7(input logic [119:0] d);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int i = 119; i >= 0; i--) begin
            fb = d[i] ^ c[6];
            c = {c[5:0], fb};
            c[3] = c[3] ^ fb;
        end
        return c;
    endfunction

endpackage

// ==== rtl/csdr_if.sv ====
// request and answer carrier between host controller and card register
`timescale 1ns/1ns
interface csdr_if;
    logic req_valid;
    csdr_pkg::csdr_cmd_t req_cmd;
    logic [15:0] req_arg;
    logic resp_valid;
    logic [127:0] resp_data;

    modport card (
        input req_valid,
        input req_cmd,
        input req_arg,
        output resp_valid,
        output resp_data
    );

    modport host (
        output req_valid,
        output req_cmd,
        output req_arg,
        input resp_valid,
        input resp_data
    );
endinterface

// ==== rtl/csdr_card.sv ====
// card end: the 128-bit card specific data register and its timing mode
`timescale 1ns/1ns

// Notes on behaviour
// [RULE_01] top two bits carry layout code 01b
// [RULE_02] access-time code fixed at 0Eh, 1 ms
// [RULE_03] access-time: unit 2:0, multiplier 6:3, bit7 reserved
// [RULE_04] host uses fixed timeouts, not timing codes
// [RULE_05] clock-cycle access field fixed 00h
// [RULE_06] rate byte: unit 2:0, multiplier 6:3
// [RULE_07] default timing reports rate 032h
// [RULE_08] high-speed timing reports rate 05Ah
// [RULE_09] switch or go-idle back restores 032h
// [RULE_10] command class mask 01x110110101b in 95:84
// [RULE_11] read block length code fixed 9h
// [RULE_12] partial read block flag is 0
// [RULE_13] write misalignment flag is 0
// [RULE_14] read misalignment flag is 0
// [RULE_15] bit 76 flags driver stage register
// [RULE_16] erase enable 1, sector size 7Fh
// [RULE_17] write block length 9, partial write 0
// [RULE_18] protect group enable 0, size zero
// [RULE_19] fields unsigned, leftmost bit most significant
// [RULE_20] device size 22 bits, top six zero
// [RULE_21] temporary protection settable, blocks writes, erases
// [RULE_22] copy flag set once, never cleared; here reset clears it
// [RULE_23] bit0 is 1, bits 7:1 checksum
// [RULE_24] fixed fields ignore any programming attempt
module csdr_card (
    input wire logic i_core_clk,              // core clock
    input wire logic i_rst,                   // synchronous reset, high
    csdr_if.card bus,                         // link to host controller
    input wire logic i_driver_stage_present,  // driver stage built in
    input wire logic [21:0] i_device_size,    // capacity code
    output logic o_high_speed,                // high-speed timing active
    output logic o_write_allowed,             // write and erase permitted
    output logic [15:0] o_driver_stage,       // driver stage setting
    output logic [127:0] o_card_data          // current register image
);
    import csdr_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // reset clears protection and copy; no nonvolatile store
    typedef struct packed {
        logic high_speed;
        logic tmp_prot;
        logic perm_prot;
        logic copy;
        logic [15:0] dsr;
        logic resp_valid;
        logic [127:0] resp_data;
        // live view, built from next state, in step with the state flops
        logic [127:0] image;
    } csdr_card_state_t;

    csdr_card_state_t s_q;
    csdr_card_state_t s_d;

    // ------------------------------------------------------------
    // image assembly
    // ------------------------------------------------------------
    // all fixed fields come from constants or the i_device_size and
    // i_driver_stage_present inputs, so nothing the host sends can reach them
    function automatic logic [127:0] build_image(
        input logic hs,
        input logic tmp,
        input logic perm,
        input logic cpy,
        input logic dsp,
        input logic [21:0] size
    );
        csdr_image_t im;

        // clearing first zeroes every reserved bit
        im = '0;
        im.layout_version_code = CSDR_LAYOUT_V2;                         // RULE_01
        im.read_access_time_code = CSDR_ACCESS_TIME;                     // RULE_02
        im.clock_cycle_access_time = CSDR_CLK_ACCESS;                    // RULE_05
        if (hs) begin
            im.transfer_rate_code = CSDR_RATE_HIGH; // RULE_08
        end else begin
            im.transfer_rate_code = CSDR_RATE_DEFAULT; // RULE_07
        end

        im.command_classes = CSDR_CMD_CLASSES;                           // RULE_10
        im.max_read_block_length = CSDR_BLOCK_LEN_512;                   // RULE_11
        im.partial_read_block_flag = 1'b0;                               // RULE_12
        im.write_misalignment_flag = 1'b0;                               // RULE_13
        im.read_misalignment_flag = 1'b0;                                // RULE_14
        im.driver_stage_present = dsp;                                   // RULE_15

        // upper six bits held low whatever the strap says
        im.device_size = {6'h00, size[CSDR_SIZE_LIVE_W-1:0]};            // RULE_20

        im.single_block_erase_enable = 1'b1;                             // RULE_16
        im.erase_sector_size = CSDR_SECTOR_SIZE;                         // RULE_16
        im.protect_group_size = 7'h00;                                   // RULE_18
        im.protect_group_enable = 1'b0;                                  // RULE_18
        // fixed code; hosts keep their own timeouts
        im.write_speed_factor = CSDR_WRITE_SPEED;
        im.max_write_block_length = CSDR_BLOCK_LEN_512;                  // RULE_17
        im.partial_write_block_flag = 1'b0;                              // RULE_17

        // protection and copy come from the next-state values of the flops
        im.file_format_group_bit = 1'b0;
        im.copy_flag = cpy;
        im.permanent_protection_bit = perm;
        im.temporary_protection_bit = tmp;
        im.file_format = 2'h0;

        // checksum covers all above it, so it goes last
        im.checksum = csdr_crc7(im[127:8]);                              // RULE_23
        im.stop_bit = 1'b1;                                              // RULE_23
        return im;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.resp_valid = 1'b0;

        // one answer per request; the host drops its request on the
        // edge that sees the answer, so a request is never taken twice
        if (bus.req_valid && !s_q.resp_valid) begin
            case (bus.req_cmd)
                CSDR_CMD_READ: begin
                    // a read only answers
                end

                CSDR_CMD_PROGRAM: begin
                    // once-only bits only ever move toward 1
                    s_d.copy = s_q.copy | bus.req_arg[CSDR_ARG_COPY];              // RULE_22
                    s_d.perm_prot = s_q.perm_prot | bus.req_arg[CSDR_ARG_PERM];

                    // temporary protection may go either way
                    s_d.tmp_prot = bus.req_arg[CSDR_ARG_TMP];                      // RULE_21
                end

                CSDR_CMD_SWITCH: begin
                    // bit 0 set means high-speed
                    s_d.high_speed = bus.req_arg[CSDR_ARG_HS];                     // RULE_09
                end

                CSDR_CMD_IDLE: begin
                    // go-idle always means default timing
                    s_d.high_speed = 1'b0;                                         // RULE_09
                end

                CSDR_CMD_SET_DSR: begin
                    // no driver stage, no register to load
                    if (i_driver_stage_present) begin                              // RULE_15
                        s_d.dsr = bus.req_arg;
                    end
                end

                default: begin
                    // unused codes answered, nothing moves
                end
            endcase

            s_d.resp_valid = 1'b1;
            s_d.resp_data = build_image(s_d.high_speed, s_d.tmp_prot, s_d.perm_prot,
                                        s_d.copy, i_driver_stage_present, i_device_size);
        end

        // fixed fields rebuilt every cycle from constants and the size and driver-stage inputs
        s_d.image = build_image(s_d.high_speed, s_d.tmp_prot, s_d.perm_prot,
                                s_d.copy, i_driver_stage_present, i_device_size); // RULE_24
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // reset: default timing, unprotected, stage at default
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s_q.high_speed <= 1'b0;                                       // RULE_07
            s_q.tmp_prot <= 1'b0;
            s_q.perm_prot <= 1'b0;
            s_q.copy <= 1'b0;
            s_q.dsr <= CSDR_DSR_RESET;

            s_q.resp_valid <= 1'b0;
            s_q.resp_data <= '0;
            s_q.image <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // answer comes straight from flops
    assign bus.resp_valid = s_q.resp_valid;
    assign bus.resp_data = s_q.resp_data;

    assign o_high_speed = s_q.high_speed;
    // either protection bit shuts out every write and erase
    assign o_write_allowed = !s_q.tmp_prot && !s_q.perm_prot;             // RULE_21
    assign o_driver_stage = s_q.dsr;
    // image lags reset by one edge, reads zero until then
    assign o_card_data = s_q.image;

endmodule

// ==== tb/csdr_properties.sv ====
// concurrent checks on the host-to-card link
`timescale 1ns/1ns
module csdr_properties (
    input wire logic i_core_clk,               // core clock
    input wire logic i_rst,                    // synchronous reset
    input wire logic req_valid,                // host request
    input wire logic [2:0] req_cmd,            // command code
    input wire logic [15:0] req_arg,           // argument
    input wire logic resp_valid,               // card answer strobe
    input wire logic [127:0] resp_data         // answered image
);
    import csdr_pkg::*;
    logic copy_q;
    // remembers a copy flag once answered as set
    always_ff @(posedge i_core_clk) begin
        if (i_rst) copy_q <= 1'b0;
        else if (resp_valid && resp_data[14]) copy_q <= 1'b1;
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    a_resp_pulse: assert property (resp_valid |=> !resp_valid)
        else $error("answer strobe longer than one cycle");
    a_resp_latency: assert property ($rose(req_valid) |=> resp_valid)
        else $error("answer not one cycle after request");
    a_req_held: assert property (req_valid && !resp_valid |=>
        req_valid && $stable(req_cmd) && $stable(req_arg)) else $error("request dropped early");
    a_layout_time: assert property (
        resp_valid |-> resp_data[127:104] == 24'h400E00) else $error("layout or access field");
    a_rate_high: assert property (
        resp_valid && req_cmd == CSDR_CMD_SWITCH && req_arg[0] |-> resp_data[103:96] == 8'h5A)
        else $error("high speed rate byte wrong");
    a_rate_default: assert property (resp_valid && (req_cmd == CSDR_CMD_IDLE ||
        req_cmd == CSDR_CMD_SWITCH && !req_arg[0]) |-> resp_data[103:96] == 8'h32)
        else $error("default rate byte wrong");
    a_class_block: assert property (
        resp_valid |-> resp_data[95:77] == {12'h5B5, 4'h9, 3'h0}) else $error("class or block");
    a_size_top: assert property (
        resp_valid |-> resp_data[75:64] == 12'h000) else $error("size top bits not zero");
    a_erase_wp: assert property (resp_valid |-> resp_data[47:21] ==
        {1'b0, 1'b1, 7'h7F, 7'h00, 1'b0, 2'h0, 3'h2, 4'h9, 1'b0}) else $error("erase or wp fields");
    a_copy_sticky: assert property (
        resp_valid && copy_q |-> resp_data[14]) else $error("copy flag cleared");
    a_tmp_program: assert property (
        resp_valid && req_cmd == CSDR_CMD_PROGRAM |-> resp_data[12] == req_arg[0])
        else $error("temporary protection not taken");
    a_stop_bit: assert property (resp_valid |-> resp_data[0] &&
        resp_data[20:15] == 6'h00 && resp_data[11:8] == 4'h0) else $error("stop or reserved bits");
endmodule

// ==== tb/card_specific_data_register_bench.sv ====
// self-checking bench joining host and card ends
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module card_specific_data_register_bench;
    import csdr_pkg::*;
    logic clk, rst, rd, wr, wt, hs, tmp, perm, cpy, dsp, o_hs, o_wa;
    logic [5:0] adr;
    logic [31:0] wd, rdata, rdata2, rdq, rdq2, e;
    logic [21:0] size;
    logic [15:0] dsr, r, o_ds;
    logic [127:0] im, o_cd;
    logic [31:0] exq[$];
    int err_total, n_checks, cyc;
    csdr_if bus();
    csdr_if bus2();
    // fault end: a card that never answers
    assign bus2.resp_valid = 1'b0;
    assign bus2.resp_data = '1;
    csdr_card csdr_card_i (.i_core_clk(clk), .i_rst(rst), .bus(bus.card),
        .i_driver_stage_present(dsp), .i_device_size(size), .o_high_speed(o_hs),
        .o_write_allowed(o_wa), .o_driver_stage(o_ds), .o_card_data(o_cd));
    csdr_host #(.READ_TIMEOUT_CYCLES(20), .WRITE_TIMEOUT_CYCLES(30)) csdr_host_i (
        .i_core_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wt), .bus(bus.host));
    csdr_host #(.READ_TIMEOUT_CYCLES(20), .WRITE_TIMEOUT_CYCLES(30)) csdr_host_fault_i (
        .i_core_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata2),
        .o_avs_waitrequest(), .bus(bus2.host));
    csdr_properties csdr_properties_i (.i_core_clk(clk), .i_rst(rst), .req_valid(bus.req_valid),
        .req_cmd(bus.req_cmd), .req_arg(bus.req_arg), .resp_valid(bus.resp_valid),
        .resp_data(bus.resp_data));
    function automatic logic [127:0] img();
        logic [127:0] v;
        logic [6:0] c;
        logic fb;
        v = {2'h1, 6'h0, 8'h0E, 8'h00, hs ? 8'h5A : 8'h32, 12'h5B5, 4'h9, 3'h0, dsp, 12'h0,
            size[15:0], 2'h1, 7'h7F, 8'h00, 2'h0, 3'h2, 4'h9, 7'h00, cpy, perm, tmp, 12'h001};
        c = 7'h00;
        // own checksum, x^7 + x^3 + 1 over the upper 120 bits
        for (int i = 127; i >= 8; i--) begin
            fb = v[i] ^ c[6];
            c = {c[5:0], fb};
            c[3] = c[3] ^ fb;
        end
        v[7:1] = c;
        return v;
    endfunction
    // one Avalon access; a read with c set notes d as its expected data
    task automatic av(input logic [5:0] a, input logic w, input logic [31:0] d, input bit c);
        if (c) exq.push_back(d);
        adr <= a;
        rd <= !w;
        wr <= w;
        wd <= d;
        @(posedge clk);
        while (wt) @(posedge clk);
        rdq = rdata;
        rdq2 = rdata2;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cmd(input logic [2:0] k, input logic [15:0] a);
        av(6'h04, 1'b1, {16'h0, a}, 1'b0);
        av(6'h00, 1'b1, {29'h0, k}, 1'b0);
        rdq = 32'h0;
        while (!rdq[1]) av(6'h08, 1'b0, 32'h0, 1'b0);
        case (k)
            3'h1: begin tmp = a[0]; perm |= a[1]; cpy |= a[2]; end
            3'h2: hs = a[0];
            3'h3: hs = 1'b0;
            3'h4: if (dsp) dsr = a;
            default: ;
        endcase
        im = img();
        for (int i = 0; i < 4; i++) av(6'h10 + 6'(4 * i), 1'b0, im[32 * i +: 32], 1'b1);
        av(6'h08, 1'b0, 32'hA, 1'b1);
        av(6'h0C, 1'b0, {16'h0, im[118:115], 1'b0, im[114:112], im[102:99], 1'b0,
            im[98:96]}, 1'b1);
        `CHK({o_hs, o_wa, o_ds, o_cd}, {hs, !(tmp | perm), dsr, im})
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // result side: each completed read takes the oldest note
    always @(negedge clk) begin
        cyc++;
        if (cyc > 5000) begin err_total++; end_sim(); end
        else if (rd && !wt && exq.size() > 0) begin e = exq.pop_front(); `CHK(rdata, e) end
    end
    initial begin
        {rst, rd, wr, adr, wd, hs, tmp, perm, cpy} = {1'b1, 44'h0};
        void'($urandom(42175));
        size = 22'($urandom);
        dsp = 1'b1;
        dsr = 16'h0404;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        cmd(3'h0, 16'h0);
        cmd(3'h2, 16'h1);
        cmd(3'h0, 16'h0);
        cmd(3'h1, 16'h1);
        cmd(3'h1, 16'h4);
        cmd(3'h1, 16'h0);
        cmd(3'h2, 16'h0);
        cmd(3'h2, 16'h1);
        cmd(3'h3, 16'h0);
        r = 16'($urandom);
        cmd(3'h4, r);
        dsp <= 1'b0;
        cmd(3'h4, ~r);
        cmd(3'h5, 16'($urandom));
        r = 16'($urandom);
        cmd(3'h1, {r[15:3], 3'b010});
        av(6'h20, 1'b0, 32'h0, 1'b1);
        av(6'h08, 1'b1, 32'hFFFF, 1'b0);
        repeat (40) @(posedge clk);
        av(6'h08, 1'b0, 32'hA, 1'b1);
        `CHK(rdq2[2:0], 3'b100)
        end_sim();
    end
endmodule
